// ===== serial_pin_strap_and_mux_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// Strap and mux bench
// ****************************************************************
module serial_pin_strap_and_mux_tb;
  logic clock, rst_n, port_a_rx, irq_request, serial_irq_frame, acpi_mode, pm_event;
  logic [2:0] strap_lvl;
  logic [3:0] modem_cond, port_a_status, port_b_status, host_addr_hi;
  logic [11:0] config_port_base;
  logic port_a_tx_in, port_a_term_ready_in, port_a_req_send_in, port_a_clear_send_n;
  logic port_a_set_ready_n, port_a_carrier_n, port_a_ring_n, port_b_rx, port_b_clear_send_n;
  logic port_b_set_ready_n, port_b_carrier_n, port_b_ring_n, uart_a_tx, uart_a_term_ready;
  logic uart_a_req_send, uart_b_tx, uart_b_term_ready, uart_b_req_send, infrared_tx;
  logic wide_decode_sel_n, irq_style_sel, infrared_sel, ref_freq_sel, sw_strap_wr;
  logic sw_wide_decode, sw_addr_sel, sw_pnp_default, port_a_tx_out, port_a_tx_oe;
  logic port_a_term_ready_n, port_a_term_ready_oe, port_a_req_send_n, port_a_req_send_oe;
  logic port_b_tx, port_b_term_ready_n, port_b_req_send_n, uart_a_rx, uart_b_rx, infrared_rx;
  logic wide_decode_strap, config_port_addr_sel, pnp_default_sel, strap_done, ref_freq_48;
  logic host_addr_hi_valid, irq_pin, serial_irq_out, mgmt_interrupt_n, acpi_ctrl_interrupt_n;
  int failures, n_checks, i;

  spsm_top dut (.*);
  spsm_far far (.*);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task chk(input [15:0] got, input [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Lets the edge's updates land before anything is read
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task do_reset(input [2:0] s);
    @(posedge clock);
    rst_n <= 1'b0;
    strap_lvl <= s;
    step(1);
    @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 12 && strap_done !== 1'b1; i++) step(1);
    if (strap_done !== 1'b1) begin
      failures++;
      print_verdict();
    end
  endtask

  initial begin
    failures = 0;
    n_checks = 0;
    rst_n = 1'b0;
    strap_lvl = 3'h5;
    modem_cond = 4'h0;
    {port_b_ring_n, port_b_carrier_n, port_b_set_ready_n, port_b_clear_send_n} = 4'hf;
    {port_b_rx, port_a_rx, uart_a_tx, uart_b_tx, infrared_tx} = 5'h1f;
    {uart_a_term_ready, uart_a_req_send, uart_b_term_ready, uart_b_req_send} = 4'hf;
    {wide_decode_sel_n, irq_style_sel, infrared_sel, ref_freq_sel} = 4'h8;
    {sw_strap_wr, sw_wide_decode, sw_addr_sel, sw_pnp_default} = 4'h0;
    {irq_request, serial_irq_frame, acpi_mode, pm_event} = 4'h0;
    do_reset(3'h5);
    chk({wide_decode_strap, config_port_addr_sel, pnp_default_sel}, 3'h5);
    chk(config_port_base, 12'h250);
    do_reset(3'h2);
    chk({wide_decode_strap, config_port_addr_sel, pnp_default_sel}, 3'h2);
    chk(config_port_base, 12'h3f0);
    // Back to back rewrites, last one wins
    @(posedge clock);
    sw_strap_wr <= 1'b1;
    {sw_wide_decode, sw_addr_sel, sw_pnp_default} <= 3'h5;
    @(posedge clock);
    {sw_wide_decode, sw_addr_sel, sw_pnp_default} <= 3'h3;
    @(posedge clock);
    sw_strap_wr <= 1'b0;
    step(3);
    chk({wide_decode_strap, config_port_addr_sel, pnp_default_sel, config_port_base}, 15'h33f0);
    $display("strap tests done");
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      modem_cond <= 4'h1 << i;
      step(4);
      chk(port_a_status, 4'h1 << i);
    end
    @(posedge clock);
    {port_b_ring_n, port_b_carrier_n, port_b_set_ready_n, port_b_clear_send_n} <= 4'h6;
    step(4);
    chk(port_b_status, 4'h9);
    @(posedge clock);
    wide_decode_sel_n <= 1'b0;
    step(4);
    chk({port_b_status, host_addr_hi_valid, host_addr_hi}, 9'h016);
    $display("modem tests done");
    @(posedge clock);
    {wide_decode_sel_n, irq_style_sel, irq_request} <= 3'h7;
    step(2);
    chk({serial_irq_out, irq_pin}, 2'h0);
    @(posedge clock);
    serial_irq_frame <= 1'b1;
    step(2);
    chk({serial_irq_out, irq_pin}, 2'h2);
    @(posedge clock);
    irq_style_sel <= 1'b0;
    step(2);
    chk({serial_irq_out, irq_pin}, 2'h3);
    for (i = 0; i < 3; i++) begin
      @(posedge clock);
      {pm_event, acpi_mode} <= (i == 2) ? 2'h0 : {1'b1, i[0]};
      step(2);
      chk({mgmt_interrupt_n, acpi_ctrl_interrupt_n}, i + 1);
    end
    @(posedge clock);
    {uart_a_term_ready, uart_a_req_send, uart_a_tx, ref_freq_sel} <= 4'h9;
    {uart_b_term_ready, uart_b_req_send, port_a_rx} <= 3'h4;
    // Three edges so the synchronised receive line has landed too
    step(3);
    chk({port_a_term_ready_n, port_a_req_send_n, port_a_tx_out}, 3'h2);
    chk({port_a_term_ready_in, port_a_req_send_in, ref_freq_48}, 3'h3);
    chk({port_b_term_ready_n, port_b_req_send_n, uart_a_rx}, 3'h2);
    chk({port_a_tx_oe, port_a_term_ready_oe, port_a_req_send_oe}, 3'h7);
    @(posedge clock);
    {infrared_sel, port_b_rx, infrared_tx, uart_b_tx} <= 4'h9;
    step(4);
    chk({infrared_rx, uart_b_rx, port_b_tx}, 3'h2);
    @(posedge clock);
    infrared_sel <= 1'b0;
    step(4);
    chk({infrared_rx, uart_b_rx, port_b_tx}, 3'h5);
    $display("mux tests done");
    print_verdict();
  end
endmodule

// ===== spsm_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// Strap capture and pin mux checker
// ****************************************************************
module spsm_chk (
  input wire clock,
  input wire rst_n,
  input wire strap_done,
  input wire port_a_tx_in,
  input wire port_a_term_ready_in,
  input wire port_a_req_send_in,
  input wire port_a_tx_oe,
  input wire wide_decode_strap,
  input wire config_port_addr_sel,
  input wire pnp_default_sel,
  input wire [11:0] config_port_base,
  input wire sw_strap_wr,
  input wire sw_wide_decode,
  input wire sw_addr_sel,
  input wire sw_pnp_default,
  input wire wide_decode_sel_n,
  input wire port_b_clear_send_n,
  input wire port_b_set_ready_n,
  input wire port_b_carrier_n,
  input wire port_b_ring_n,
  input wire [3:0] host_addr_hi,
  input wire irq_style_sel,
  input wire serial_irq_frame,
  input wire serial_irq_out,
  input wire irq_pin,
  input wire pm_event,
  input wire acpi_mode,
  input wire mgmt_interrupt_n,
  input wire acpi_ctrl_interrupt_n,
  input wire uart_a_term_ready,
  input wire port_a_term_ready_n,
  input wire infrared_sel,
  input wire port_b_rx,
  input wire infrared_rx,
  input wire infrared_tx,
  input wire uart_b_tx,
  input wire port_b_tx
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Pins are held steady across reset, so a three deep look back is safe
  chk_strap_capture: assert property ($rose(strap_done) |-> port_a_tx_oe &&
    {wide_decode_strap, config_port_addr_sel, pnp_default_sel} ==
    $past({port_a_tx_in, port_a_term_ready_in, port_a_req_send_in}, 3)) else $error("strap");
  chk_port_base: assert property (config_port_base ==
    (config_port_addr_sel ? 12'h3f0 : 12'h250)) else $error("base");
  chk_strap_hold: assert property (strap_done && $past(strap_done) |->
    {wide_decode_strap, config_port_addr_sel, pnp_default_sel} == ($past(sw_strap_wr) ?
    $past({sw_wide_decode, sw_addr_sel, sw_pnp_default}) :
    $past({wide_decode_strap, config_port_addr_sel, pnp_default_sel}))) else $error("hold");
  chk_wide_addr: assert property (strap_done && !$past(wide_decode_sel_n) |->
    host_addr_hi == $past({port_b_ring_n, port_b_carrier_n, port_b_set_ready_n,
    port_b_clear_send_n}, 3)) else $error("addr");
  chk_serial_irq: assert property (strap_done && $past(irq_style_sel) |->
    serial_irq_out == $past(serial_irq_frame) && !irq_pin) else $error("serial_irq_out");
  chk_pm_irq: assert property (strap_done |->
    mgmt_interrupt_n == !$past(pm_event && !acpi_mode) &&
    acpi_ctrl_interrupt_n == !$past(pm_event && acpi_mode)) else $error("pm");
  chk_term_ready: assert property (strap_done |->
    port_a_term_ready_n == !$past(uart_a_term_ready)) else $error("dtr");
  chk_ir_rx: assert property (strap_done && $past(infrared_sel) |->
    infrared_rx == $past(port_b_rx, 3)) else $error("irrx");
  chk_ir_tx: assert property (strap_done |-> port_b_tx ==
    ($past(infrared_sel) ? $past(infrared_tx) : $past(uart_b_tx))) else $error("irtx");
endmodule
bind spsm_top spsm_chk chk (.*);

// ===== spsm_far.sv
`timescale 1ns/1ps
// ****************************************************************
// Far side: strap resistors and modem
// ****************************************************************
module spsm_far (
  input wire port_a_tx_out,
  input wire port_a_tx_oe,
  input wire port_a_term_ready_n,
  input wire port_a_term_ready_oe,
  input wire port_a_req_send_n,
  input wire port_a_req_send_oe,
  input wire [2:0] strap_lvl,
  input wire [3:0] modem_cond,
  output wire port_a_tx_in,
  output wire port_a_term_ready_in,
  output wire port_a_req_send_in,
  output wire port_a_clear_send_n,
  output wire port_a_set_ready_n,
  output wire port_a_carrier_n,
  output wire port_a_ring_n
);
  // Released pin falls to its strap resistor level
  assign port_a_tx_in = port_a_tx_oe ? port_a_tx_out : strap_lvl[2];
  assign port_a_term_ready_in = port_a_term_ready_oe ? port_a_term_ready_n : strap_lvl[1];
  assign port_a_req_send_in = port_a_req_send_oe ? port_a_req_send_n : strap_lvl[0];
  assign {port_a_ring_n, port_a_carrier_n, port_a_set_ready_n, port_a_clear_send_n} =
    ~modem_cond;
endmodule

// ===== spsm_regs.vh
`ifndef SPSM_REGS_VH
`define SPSM_REGS_VH

// ****************************************************************
// Strap bit positions inside the configuration bytes
// ****************************************************************
`define SPSM_CONFIG_REG_2E_WIDE_DECODE_BIT 6
`define SPSM_CONFIG_REG_16_ADDR_SEL_BIT 0
`define SPSM_CONFIG_REG_16_PNP_BIT 2
`define SPSM_CONFIG_REG_16_WIDE_SEL_N_BIT 6
`define SPSM_CONFIG_REG_31_IRQ_STYLE_BIT 2

// ****************************************************************
// Reset values, matching the internal pull on each strap pin
// ****************************************************************
`define SPSM_WIDE_DECODE_RST 1'b1
`define SPSM_ADDR_SEL_RST 1'b0
`define SPSM_PNP_RST 1'b1
`define SPSM_LINE_IDLE 1'b1

// ****************************************************************
// Configuration port bases
// ****************************************************************
`define SPSM_CFG_PORT_LOW 12'h250
`define SPSM_CFG_PORT_HIGH 12'h3f0

// ****************************************************************
// Timing
// ****************************************************************
`define SPSM_SYNC_STAGES 2
`define SPSM_STRAP_SETTLE_CYC 3'h4

`endif

// ===== spsm_sync.v
`timescale 1ns/1ps

// ****************************************************************
// Two-stage synchroniser for pin inputs
// ****************************************************************
module spsm_sync #(
  parameter WIDTH = 13
) (
  input wire clock,
  input wire rst_n,
  input wire [WIDTH-1:0] pin_in,
  input wire [WIDTH-1:0] rst_val,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  // First stage feeds only the second stage
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{1'b1}};
      stable <= {WIDTH{1'b1}};
    end else begin
      meta <= pin_in;
      stable <= meta;
    end
  end

  assign sync_out = stable;

endmodule

// ===== spsm_top.v
`timescale 1ns/1ps
`include "spsm_regs.vh"

// Operation
// - Sample port A tx pin into wide-decode strap
// - Sample port A term-ready pin into address select
// - Sample port A request-send pin into PnP strap
// - Wide decode: port B modem pins are address
// - Serial IRQ style drives serial interrupt output
// - Power events pull management or ACPI interrupt low
// - Low modem status inputs mean asserted
// - Drive term-ready and request-send low when ready
// - Infrared selected: port B rx pin is IR
// - Infrared selected: port B tx pin carries IR

module spsm_top (
  input wire clock,
  input wire rst_n,
  // Port A modem and serial pins
  input wire port_a_clear_send_n,
  input wire port_a_set_ready_n,
  input wire port_a_carrier_n,
  input wire port_a_ring_n,
  input wire port_a_rx,
  input wire port_a_tx_in,
  output reg port_a_tx_out,
  output reg port_a_tx_oe,
  input wire port_a_term_ready_in,
  output reg port_a_term_ready_n,
  output reg port_a_term_ready_oe,
  input wire port_a_req_send_in,
  output reg port_a_req_send_n,
  output reg port_a_req_send_oe,
  // Port B pins, modem inputs shared with host address bits
  input wire port_b_clear_send_n,
  input wire port_b_set_ready_n,
  input wire port_b_carrier_n,
  input wire port_b_ring_n,
  input wire port_b_rx,
  output reg port_b_tx,
  output reg port_b_term_ready_n,
  output reg port_b_req_send_n,
  // UART core side
  input wire uart_a_tx,
  input wire uart_a_term_ready,
  input wire uart_a_req_send,
  input wire uart_b_tx,
  input wire uart_b_term_ready,
  input wire uart_b_req_send,
  input wire infrared_tx,
  output reg uart_a_rx,
  output reg [3:0] port_a_status,
  output reg uart_b_rx,
  output reg [3:0] port_b_status,
  output reg infrared_rx,
  // Configuration bits
  input wire wide_decode_sel_n,
  input wire irq_style_sel,
  input wire infrared_sel,
  input wire ref_freq_sel,
  input wire sw_strap_wr,
  input wire sw_wide_decode,
  input wire sw_addr_sel,
  input wire sw_pnp_default,
  output reg wide_decode_strap,
  output reg config_port_addr_sel,
  output reg pnp_default_sel,
  output reg [11:0] config_port_base,
  output reg strap_done,
  output reg ref_freq_48,
  // Address decode and interrupts
  output reg [3:0] host_addr_hi,
  output reg host_addr_hi_valid,
  input wire irq_request,
  input wire serial_irq_frame,
  output reg irq_pin,
  output reg serial_irq_out,
  input wire acpi_mode,
  input wire pm_event,
  output reg mgmt_interrupt_n,
  output reg acpi_ctrl_interrupt_n
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam NPIN = 13;

  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_s;

  assign pin_raw = {port_a_req_send_in, port_a_term_ready_in, port_a_tx_in,
                    port_b_rx, port_b_ring_n, port_b_carrier_n,
                    port_b_set_ready_n, port_b_clear_send_n, port_a_rx,
                    port_a_ring_n, port_a_carrier_n, port_a_set_ready_n,
                    port_a_clear_send_n};

  spsm_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(pin_raw),
    .rst_val({NPIN{1'b1}}),
    .sync_out(pin_s)
  );

  wire [3:0] a_modem_n;
  wire [3:0] b_modem_n;
  wire a_rx_s;
  wire b_rx_s;
  wire strap_tx_s;
  wire strap_dtr_s;
  wire strap_rts_s;

  assign a_modem_n = pin_s[3:0];
  assign a_rx_s = pin_s[4];
  assign b_modem_n = pin_s[8:5];
  assign b_rx_s = pin_s[9];
  assign strap_tx_s = pin_s[10];
  assign strap_dtr_s = pin_s[11];
  assign strap_rts_s = pin_s[12];

  // ****************************************************************
  // Strap sequencer
  // ****************************************************************
  // Pins stay released after reset until the synchronisers hold
  // settled levels; pulls decide the value on an open strap pin.
  localparam ST_SETTLE = 3'b001;
  localparam ST_CAPTURE = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] settle_cnt;

  always @* begin
    next_state = state;
    case (state)
      ST_SETTLE: begin
        if (settle_cnt == `SPSM_STRAP_SETTLE_CYC) begin
          next_state = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_SETTLE;
      end
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SETTLE;
      settle_cnt <= 3'h0;
    end else begin
      state <= next_state;
      if (state == ST_SETTLE) begin
        settle_cnt <= settle_cnt + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Strap holding bits
  // ****************************************************************
  // Software may rewrite only after capture, so a write during the
  // settle window is dropped and the strap sample stands.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wide_decode_strap <= `SPSM_WIDE_DECODE_RST;
      config_port_addr_sel <= `SPSM_ADDR_SEL_RST;
      pnp_default_sel <= `SPSM_PNP_RST;
      config_port_base <= `SPSM_CFG_PORT_LOW;
      strap_done <= 1'b0;
    end else if (state == ST_CAPTURE) begin
      wide_decode_strap <= strap_tx_s;
      config_port_addr_sel <= strap_dtr_s;
      pnp_default_sel <= strap_rts_s;
      config_port_base <= strap_dtr_s ? `SPSM_CFG_PORT_HIGH : `SPSM_CFG_PORT_LOW;
      strap_done <= 1'b1;
    end else if (state == ST_RUN && sw_strap_wr) begin
      wide_decode_strap <= sw_wide_decode;
      config_port_addr_sel <= sw_addr_sel;
      pnp_default_sel <= sw_pnp_default;
      config_port_base <= sw_addr_sel ? `SPSM_CFG_PORT_HIGH : `SPSM_CFG_PORT_LOW;
    end
  end

  // ****************************************************************
  // Port A strap pins return to serial use
  // ****************************************************************
  wire run_now;

  assign run_now = (next_state == ST_RUN);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_a_tx_out <= `SPSM_LINE_IDLE;
      port_a_tx_oe <= 1'b0;
      port_a_term_ready_n <= 1'b1;
      port_a_term_ready_oe <= 1'b0;
      port_a_req_send_n <= 1'b1;
      port_a_req_send_oe <= 1'b0;
    end else begin
      port_a_tx_out <= run_now ? uart_a_tx : `SPSM_LINE_IDLE;
      port_a_tx_oe <= run_now;
      port_a_term_ready_n <= ~(run_now & uart_a_term_ready);
      port_a_term_ready_oe <= run_now;
      port_a_req_send_n <= ~(run_now & uart_a_req_send);
      port_a_req_send_oe <= run_now;
    end
  end

  // ****************************************************************
  // Port B serial and infrared routing
  // ****************************************************************
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_b_tx <= `SPSM_LINE_IDLE;
      port_b_term_ready_n <= 1'b1;
      port_b_req_send_n <= 1'b1;
      uart_b_rx <= `SPSM_LINE_IDLE;
      infrared_rx <= `SPSM_LINE_IDLE;
      uart_a_rx <= `SPSM_LINE_IDLE;
    end else begin
      port_b_tx <= infrared_sel ? infrared_tx : uart_b_tx;
      port_b_term_ready_n <= ~uart_b_term_ready;
      port_b_req_send_n <= ~uart_b_req_send;
      // Unused receiver sees an idle line, not stray IR pulses
      uart_b_rx <= infrared_sel ? `SPSM_LINE_IDLE : b_rx_s;
      infrared_rx <= infrared_sel ? b_rx_s : `SPSM_LINE_IDLE;
      uart_a_rx <= a_rx_s;
    end
  end

  // ****************************************************************
  // Modem status, one instance per port
  // ****************************************************************
  // Order in each status vector: clear-send, set-ready, carrier, ring.
  wire [7:0] modem_n;
  wire [1:0] port_active;
  wire [7:0] next_status;

  assign modem_n = {b_modem_n, a_modem_n};
  // Port B status is meaningless while its pins carry address bits
  assign port_active = {wide_decode_sel_n, 1'b1};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
      assign next_status[gi*4 +: 4] = port_active[gi] ?
        ~modem_n[gi*4 +: 4] : 4'h0;
    end
  endgenerate

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_a_status <= 4'h0;
      port_b_status <= 4'h0;
    end else begin
      port_a_status <= next_status[3:0];
      port_b_status <= next_status[7:4];
    end
  end

  // ****************************************************************
  // Upper host address bits
  // ****************************************************************
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      host_addr_hi <= 4'h0;
      host_addr_hi_valid <= 1'b0;
    end else begin
      host_addr_hi <= wide_decode_sel_n ? 4'h0 : b_modem_n;
      host_addr_hi_valid <= ~wide_decode_sel_n;
    end
  end

  // ****************************************************************
  // Interrupt pin style, clock select and power events
  // ****************************************************************
  // Request and event inputs come from logic on this clock.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_pin <= 1'b0;
      serial_irq_out <= 1'b1;
      ref_freq_48 <= 1'b0;
      mgmt_interrupt_n <= 1'b1;
      acpi_ctrl_interrupt_n <= 1'b1;
    end else begin
      irq_pin <= irq_style_sel ? 1'b0 : irq_request;
      serial_irq_out <= irq_style_sel ? serial_irq_frame : 1'b1;
      // Divider trusts software to match the real clock input
      ref_freq_48 <= ref_freq_sel;
      mgmt_interrupt_n <= ~(pm_event & ~acpi_mode);
      acpi_ctrl_interrupt_n <= ~(pm_event & acpi_mode);
    end
  end

endmodule
